// ### src/shutter_seq_pkg.sv
package shutter_seq_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL       = 8'hc0;
  localparam logic [7:0] IDX_INTEG_TIME = 8'hc1;
  localparam logic [7:0] IDX_READ_TIME  = 8'hc2;
  localparam logic [7:0] IDX_STB_ON     = 8'hc3;
  localparam logic [7:0] IDX_STB_OFF    = 8'hc4;
  localparam logic [7:0] IDX_FLS_ON     = 8'hc5;
  localparam logic [7:0] IDX_FLS_OFF    = 8'hc6;
  localparam logic [7:0] IDX_STATUS     = 8'hc7;

  localparam int ADDR_W = 10;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_START_BIT = 15;
  localparam int CTRL_FLS_BIT   = 2;
  localparam int CTRL_STB_BIT   = 1;
  localparam int CTRL_READ_BIT  = 0;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_STB_BIT   = 4;
  localparam int STAT_FLS_BIT   = 5;
  localparam int STAT_CNT_LSB   = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0]  RST_CTRL       = 3'h0;
  localparam logic [15:0] RST_INTEG_TIME = 16'h0064;
  localparam logic [15:0] RST_READ_TIME  = 16'h0064;
  localparam logic [15:0] RST_STB_ON     = 16'h0096;
  localparam logic [15:0] RST_STB_OFF    = 16'h00c8;
  localparam logic [15:0] RST_FLS_ON     = 16'h0064;
  localparam logic [15:0] RST_FLS_OFF    = 16'h0078;

  // ----------------------------------------------------------------------
  // Counter and timing
  // ----------------------------------------------------------------------
  localparam int CNT_W      = 24;
  localparam int THR_W      = 16;
  localparam int THR_LSB    = 8;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int MIN_GRST_TIME_NS = 1000;
  localparam logic [23:0] MIN_GRST_CYC =
    24'((MIN_GRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_GRST  = 4'b0010,
    ST_INTEG = 4'b0100,
    ST_READ  = 4'b1000
  } seq_state_t;

endpackage : shutter_seq_pkg

// ### src/thr_match.sv
`timescale 1ns/10ps
// Compares one threshold against the counter's upper bits
module thr_match #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] thr_in,   // Programmed threshold
  input  wire logic [W-1:0] cnt_in,   // Counter upper bits
  output logic              eq_out,   // Exact match
  output logic              ge_out    // Counter at or past threshold
);

  // Plain comparators, effective in the same cycle
  assign eq_out = (cnt_in == thr_in);
  assign ge_out = (cnt_in >= thr_in);

endmodule : thr_match

// ### src/shutter_seq.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// RL1 - With the readout-control bit set, readout starts on a falling edge of the snapshot control pin, otherwise at the programmed readout time.
// RL2 - A 24-bit counter of master clocks starts from zero when global reset begins and feeds every threshold compare.
// RL3 - When the counter's upper bits reach the integration start value, global reset is released and integration begins.
// RL4 - Global reset is held for a fixed minimum time even when the integration start value would end it sooner.
// RL5 - Readout begins when the counter reaches the integration start value plus the readout offset.
// RL6 - The strobe output is asserted when the counter reaches the strobe-on value.
// RL7 - The strobe is released at the strobe-off value only when the strobe-control bit is 0.
// RL8 - The flash output is asserted when the counter reaches the flash-on value.
// RL9 - Writing 1 to the start bit begins the global reset sequence, and that bit always reads as 0.
// RL10 - With the strobe-control bit set, the strobe is released at the end of readout.
// RL11 - With the flash-control bit set, the flash is released at the end of readout.
// RL12 - The flash is released at the flash-off value only when the flash-control bit is 0.
// RL13 - Thresholds compare against counter bits 23 to 8 and act in the cycle of the match.
module shutter_seq
  import shutter_seq_pkg::*;
(
  input  wire logic              clk_in,                // 25 MHz clock
  input  wire logic              sys_rst_in,            // Sync reset, high
  input  wire logic              ce_in,                 // Clock enable
  input  wire logic              psel,                  // APB select
  input  wire logic              penable,               // APB enable
  input  wire logic              pwrite,                // APB write
  input  wire logic [ADDR_W-1:0] paddr,                 // APB byte address
  input  wire logic [31:0]       pwdata,                // APB write data
  output logic      [31:0]       prdata,                // APB read data
  output logic                   pready,                // APB ready
  output logic                   pslverr,               // APB error
  input  wire logic              snapshot_control_pin_in, // Readout pin
  input  wire logic              readout_done_in,       // End of readout
  output logic                   global_reset_out,      // Global reset
  output logic                   integrating_out,       // Integration
  output logic                   readout_out,           // Readout active
  output logic                   strobe_out,            // Strobe pin
  output logic                   flash_out              // Flash pin
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  seq_state_t        state_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [2:0]        ctrl_r;
  logic [THR_W-1:0]  integration_start_threshold_r;
  logic [THR_W-1:0]  readout_start_offset_r;
  logic [THR_W-1:0]  strobe_on_threshold_r;
  logic [THR_W-1:0]  strobe_off_threshold_r;
  logic [THR_W-1:0]  flash_on_time_r;
  logic [THR_W-1:0]  flash_off_time_r;
  logic              pin_prev_r;
  logic              strobe_r;
  logic              flash_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [31:0]       rdata_nxt;
  logic              hit_nxt;
  logic              wr_en;
  logic              start_req;
  logic [7:0]        idx;
  logic [THR_W-1:0]  cnt_hi;
  logic [THR_W:0]    read_sum;
  logic              t1_ge, t3_eq, t4_eq, f_on_eq, f_off_eq, sum_ge;
  logic              min_ok, pin_fell, busy;
  logic              integ_go, read_go, read_end;

  assign idx     = paddr[ADDR_W-1:2];
  assign wr_en   = ce_in & psel & penable & pready_r & pwrite & ~pslverr_r;
  assign cnt_hi  = cnt_r[CNT_W-1:THR_LSB];                       // RL13
  assign read_sum = {1'b0, integration_start_threshold_r}
                  + {1'b0, readout_start_offset_r};              // RL5

  // ----------------------------------------------------------------------
  // Threshold comparators
  // ----------------------------------------------------------------------
  thr_match #(.W(THR_W)) u_t1 (
    .thr_in (integration_start_threshold_r), .cnt_in (cnt_hi),
    .eq_out (), .ge_out (t1_ge));
  thr_match #(.W(THR_W)) u_t3 (
    .thr_in (strobe_on_threshold_r), .cnt_in (cnt_hi),
    .eq_out (t3_eq), .ge_out ());
  thr_match #(.W(THR_W)) u_t4 (
    .thr_in (strobe_off_threshold_r), .cnt_in (cnt_hi),
    .eq_out (t4_eq), .ge_out ());
  thr_match #(.W(THR_W)) u_fon (
    .thr_in (flash_on_time_r), .cnt_in (cnt_hi),
    .eq_out (f_on_eq), .ge_out ());
  thr_match #(.W(THR_W)) u_foff (
    .thr_in (flash_off_time_r), .cnt_in (cnt_hi),
    .eq_out (f_off_eq), .ge_out ());
  thr_match #(.W(THR_W+1)) u_sum (
    .thr_in (read_sum), .cnt_in ({1'b0, cnt_hi}),
    .eq_out (), .ge_out (sum_ge));

  // ----------------------------------------------------------------------
  // Sequence decisions
  // ----------------------------------------------------------------------
  assign busy      = (state_r != ST_IDLE);
  assign min_ok    = (cnt_r >= MIN_GRST_CYC - 24'h1);            // RL4
  assign pin_fell  = pin_prev_r & ~snapshot_control_pin_in;
  assign start_req = wr_en && idx == IDX_CTRL && pwdata[CTRL_START_BIT];
  assign integ_go  = (state_r == ST_GRST) && t1_ge && min_ok;    // RL3
  assign read_go   = (state_r == ST_INTEG) &&
                     (ctrl_r[CTRL_READ_BIT] ? pin_fell : sum_ge); // RL1
  assign read_end  = (state_r == ST_READ) && readout_done_in;

  // State machine: idle, global reset, integration, readout
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
    end else if (ce_in) begin
      unique case (state_r)
        ST_IDLE:  if (start_req) state_r <= ST_GRST;             // RL9
        ST_GRST:  if (integ_go) state_r <= ST_INTEG;             // RL3
        ST_INTEG: if (read_go) state_r <= ST_READ;               // RL5
        ST_READ:  if (read_end) state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  // Master clock counter, cleared when global reset begins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_r <= '0;
    end else if (ce_in) begin
      if (state_r == ST_IDLE) begin
        cnt_r <= '0;                                             // RL2
      end else begin
        cnt_r <= cnt_r + 24'h1;                                  // RL2
      end
    end
  end

  // Previous pin level for falling-edge detection
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_prev_r <= 1'b0;
    end else if (ce_in) begin
      pin_prev_r <= snapshot_control_pin_in;
    end
  end

  // Strobe: set wins over a strobe-off release in the same cycle, but the end of readout wins over set
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      strobe_r <= 1'b0;
    end else if (ce_in) begin
      if (busy && t3_eq && !read_end) begin
        strobe_r <= 1'b1;                                        // RL6
      end else if (read_end) begin
        strobe_r <= 1'b0;                                        // RL10
      end else if (busy && t4_eq && !ctrl_r[CTRL_STB_BIT]) begin
        strobe_r <= 1'b0;                                        // RL7
      end
    end
  end

  // Flash: same scheme as the strobe
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flash_r <= 1'b0;
    end else if (ce_in) begin
      if (busy && f_on_eq && !read_end) begin
        flash_r <= 1'b1;                                         // RL8
      end else if (read_end) begin
        flash_r <= 1'b0;                                         // RL11
      end else if (busy && f_off_eq && !ctrl_r[CTRL_FLS_BIT]) begin
        flash_r <= 1'b0;                                         // RL12
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  // Software-written settings
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_r                        <= RST_CTRL;
      integration_start_threshold_r <= RST_INTEG_TIME;
      readout_start_offset_r        <= RST_READ_TIME;
      strobe_on_threshold_r         <= RST_STB_ON;
      strobe_off_threshold_r        <= RST_STB_OFF;
      flash_on_time_r               <= RST_FLS_ON;
      flash_off_time_r              <= RST_FLS_OFF;
    end else if (wr_en) begin
      unique case (idx)
        IDX_CTRL:       ctrl_r <= pwdata[2:0];
        IDX_INTEG_TIME: integration_start_threshold_r <= pwdata[15:0];
        IDX_READ_TIME:  readout_start_offset_r <= pwdata[15:0];
        IDX_STB_ON:     strobe_on_threshold_r <= pwdata[15:0];
        IDX_STB_OFF:    strobe_off_threshold_r <= pwdata[15:0];
        IDX_FLS_ON:     flash_on_time_r <= pwdata[15:0];
        IDX_FLS_OFF:    flash_off_time_r <= pwdata[15:0];
        default:        ;
      endcase
    end
  end

  // Read mux; the start bit is never stored and reads as zero
  always_comb begin
    rdata_nxt = 32'h0;
    hit_nxt   = 1'b1;
    unique case (idx)
      IDX_CTRL:       rdata_nxt = {29'h0, ctrl_r};               // RL9
      IDX_INTEG_TIME: rdata_nxt = {16'h0, integration_start_threshold_r};
      IDX_READ_TIME:  rdata_nxt = {16'h0, readout_start_offset_r};
      IDX_STB_ON:     rdata_nxt = {16'h0, strobe_on_threshold_r};
      IDX_STB_OFF:    rdata_nxt = {16'h0, strobe_off_threshold_r};
      IDX_FLS_ON:     rdata_nxt = {16'h0, flash_on_time_r};
      IDX_FLS_OFF:    rdata_nxt = {16'h0, flash_off_time_r};
      IDX_STATUS:     rdata_nxt = {cnt_r, 2'h0, flash_r, strobe_r,
                                   state_r};
      default:        hit_nxt = 1'b0;
    endcase
  end

  // APB answer: one access cycle, captured in the setup cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else if (ce_in) begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~hit_nxt;
      if (psel && !penable && !pwrite) begin
        prdata_r <= hit_nxt ? rdata_nxt : 32'h0;
      end
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign global_reset_out = state_r[1];
  assign integrating_out  = state_r[2];
  assign readout_out      = state_r[3];
  assign strobe_out       = strobe_r;
  assign flash_out        = flash_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !ce_in);

  sequence grst_begin_s;
    $rose(global_reset_out) ##0 cnt_r == 24'h0;
  endsequence
  sequence cnt_step_s;
    ##1 cnt_r == 24'h1 ##1 cnt_r == 24'h2;
  endsequence

  cnt_start_a: assert property ($rose(global_reset_out) |->  // RL2
    grst_begin_s ##0 cnt_step_s)
    else $error("counter did not start from zero");
  grst_min_a: assert property ($fell(global_reset_out) |->  // RL4
    $past(cnt_r) >= MIN_GRST_CYC - 24'h1)
    else $error("global reset shorter than minimum");
  integ_go_a: assert property (state_r == ST_GRST && t1_ge  // RL3
    && min_ok |=> !global_reset_out && integrating_out)
    else $error("integration did not start at threshold");
  rd_pin_a: assert property (integrating_out && ctrl_r[0]  // RL1
    && $fell(snapshot_control_pin_in) |=> readout_out)
    else $error("readout missed pin falling edge");
  rd_time_a: assert property (integrating_out && !ctrl_r[0]  // RL5
    && cnt_hi >= read_sum[15:0] && !read_sum[16] |=> readout_out)
    else $error("readout missed start time");
  strobe_on_a: assert property (busy && t3_eq && !read_end  // RL6
    |=> strobe_out)
    else $error("strobe not asserted");
  strobe_off_a: assert property (busy && t4_eq && !t3_eq  // RL7
    && !ctrl_r[1] |=> !strobe_out)
    else $error("strobe not released at threshold");
  strobe_end_a: assert property (read_end |=> !strobe_out  // RL10
    && !flash_out)
    else $error("strobe held after readout");
  flash_on_a: assert property (busy && f_on_eq && !read_end  // RL8
    |=> flash_out)
    else $error("flash not asserted");
  flash_off_a: assert property (busy && f_off_eq && !f_on_eq  // RL12
    && !ctrl_r[2] |=> !flash_out)
    else $error("flash not released at threshold");
  flash_hold_a: assert property (flash_out && ctrl_r[2]  // RL11
    && !read_end && busy |=> flash_out)
    else $error("flash released before readout end");
  start_bit_a: assert property (!busy && start_req  // RL9
    |=> global_reset_out && cnt_r == 24'h0)
    else $error("start write did not enter global reset");
  ctrl_read_a: assert property (pready && !pwrite  // RL9
    && idx == IDX_CTRL |-> prdata[15] == 1'b0)
    else $error("start bit read back as one");
  cnt_hi_a: assert property (busy && $past(busy) && $past(ce_in)  // RL13
    && cnt_r[7:0] == 8'h0 |-> cnt_hi == $past(cnt_hi) + 16'h1)
    else $error("threshold step is not 256 cycles");

endmodule : shutter_seq

// ### testbench/readout_array_model.sv
`timescale 1ns/10ps
// Far side: pixel array end-of-readout and the snapshot control pin
module readout_array_model #(
  parameter int DONE_DLY = 300
) (
  input  wire logic clk_in,        // Master clock
  input  wire logic sys_rst_in,    // Sync reset, high
  input  wire logic readout_in,    // Readout in progress
  input  wire logic hold_pin_in,   // Bench wish for the pin level
  output logic      done_out,      // End-of-readout pulse
  output logic      pin_out        // Snapshot control pin level
);
  int cnt;

  // ----------------------------------------------------------------------
  // Pulse done once, a fixed time into readout
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !readout_in || done_out) begin
      cnt      <= 0;
      done_out <= 1'b0;
    end else begin
      cnt      <= cnt + 1;
      done_out <= (cnt == DONE_DLY - 1);
    end
  end

  // Pin changes only at a clock edge, like a synchronous camera host
  always_ff @(posedge clk_in) begin
    pin_out <= hold_pin_in;
  end
endmodule : readout_array_model

// ### testbench/global_reset_shutter_sequencer_test.sv
`timescale 1ns/10ps
module global_reset_shutter_sequencer_test;
  import shutter_seq_pkg::*;
  logic              clk_in     = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              psel       = 1'b0;
  logic              penable    = 1'b0;
  logic              pwrite     = 1'b0;
  logic [ADDR_W-1:0] paddr      = '0;
  logic [31:0]       pwdata     = '0;
  logic              hold_pin   = 1'b1;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              pin;
  logic              done;
  logic              grst, integ, rdo, stb, fls;
  logic [5:0]        prev = '0;
  int                t_rise [6];
  int                t_fall [6];
  int                cyc = 0;
  int                miscompares = 0;
  int                cmp_count = 0;
  logic [31:0]       rd;
  logic              err;
  logic [15:0]       rst_val [6] = '{16'h0064, 16'h0064, 16'h0096,
                                     16'h00c8, 16'h0064, 16'h0078};
  wire  [5:0]        sig = {pin, fls, stb, rdo, integ, grst};

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  shutter_seq dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .snapshot_control_pin_in(pin),
    .readout_done_in(done), .global_reset_out(grst),
    .integrating_out(integ), .readout_out(rdo), .strobe_out(stb),
    .flash_out(fls));

  readout_array_model partner (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .readout_in(rdo),
    .hold_pin_in(hold_pin), .done_out(done), .pin_out(pin));

  // Edge times of the five sequence outputs and the pin, taken where values are settled
  always @(negedge clk_in) begin
    cyc <= cyc + 1;
    prev <= sig;
    for (int i = 0; i < 6; i++) begin
      if (sig[i] === 1'b1 && prev[i] !== 1'b1) t_rise[i] <= cyc;
      if (sig[i] === 1'b0 && prev[i] === 1'b1) t_fall[i] <= cyc;
    end
  end

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Accepts any value from lo to hi; the edge-timing calls allow one cycle either way around the nominal reaction time
  task automatic rng(input string nm, input int v, lo, hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : rng

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_lvl(input int b, input logic v);
    int n;
    for (n = 0; n < 5000 && sig[b] !== v; n++) @(negedge clk_in);
    if (n >= 5000) chk("wait level", 32'(v), 32'(sig[b]));
    // Let the edge recorder store the time of this change
    @(negedge clk_in);
  endtask : wait_lvl

  // Program thresholds 0xc1..0xc6, then write control with start set
  task automatic launch(input logic [15:0] v [6], input logic [2:0] ctl);
    for (int i = 0; i < 6; i++)
      apb(1'b1, IDX_INTEG_TIME + 8'(i), {16'h0, v[i]});
    apb(1'b1, IDX_CTRL, {16'h0, 1'b1, 12'h0, ctl});
  endtask : launch

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    final_report;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    // Reset values, control, and an unmapped place
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, IDX_INTEG_TIME + 8'(i), 32'h0);
      chk("threshold reset", {16'h0, rst_val[i]}, rd);
    end
    apb(1'b0, IDX_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 8'hff, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    // Threshold timing, flash held to end of readout
    launch('{16'h1, 16'h1, 16'h1, 16'h2, 16'h1, 16'h2}, 3'b100);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk("ctrl start reads 0", 32'h4, rd);
    wait_lvl(1, 1'b1);
    repeat (10) @(posedge clk_in);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("status state", 32'h4, {28'h0, rd[3:0]});
    chk("status pins", 32'h3, {30'h0, rd[5:4]});
    rng("counter value", int'(rd[31:8]), 256, 300);
    wait_lvl(2, 1'b1);
    wait_lvl(2, 1'b0);
    repeat (2) @(negedge clk_in);
    rng("integ start", t_rise[1] - t_rise[0], 256, 258);
    rng("readout start", t_rise[2] - t_rise[0], 512, 514);
    rng("strobe on", t_rise[3] - t_rise[0], 256, 258);
    rng("strobe off", t_fall[3] - t_rise[0], 512, 514);
    rng("flash on", t_rise[4] - t_rise[0], 256, 258);
    rng("flash at end", t_fall[4] - t_fall[2], -1, 1);
    // Pin-controlled readout, minimum global reset, strobe to end
    launch('{16'h0, 16'h1, 16'h0, 16'h1, 16'h1, 16'h2}, 3'b011);
    wait_lvl(1, 1'b1);
    rng("minimum grst", t_rise[1] - t_rise[0], 24, 26);
    repeat (600) @(negedge clk_in);
    chk("readout waits pin", 32'h0, 32'(rdo));
    @(posedge clk_in);
    hold_pin <= 1'b0;
    wait_lvl(2, 1'b1);
    rng("readout on pin", t_rise[2] - t_fall[5], 0, 2);
    wait_lvl(2, 1'b0);
    hold_pin <= 1'b1;
    repeat (2) @(negedge clk_in);
    rng("strobe at end", t_fall[3] - t_fall[2], -1, 1);
    rng("flash off", t_fall[4] - t_rise[0], 512, 514);
    final_report;
  end
endmodule : global_reset_shutter_sequencer_test
